/* dbg_cfg.svh */
/*
  Constants for the debug mailbox and TAP gate: I/O addresses, bit positions,
  TAP instruction codes, data register lengths and programming targets.
  Assumes a 6-bit CPU I/O address space and an 8-bit CPU data path.
*/
`ifndef DBG_CFG_SVH
`define DBG_CFG_SVH

`define IO_AW          6
`define MBOX_ADDR      6'h31
`define CTL_STAT_ADDR  6'h34
`define MBOX_RESET     8'h00
`define CTL_STAT_RESET 8'h00
`define DIRTY_BIT      7
`define TAP_DIS_BIT    7

`define IR_LEN         4
`define IR_CAPTURE     4'h1
`define IR_PROG        4'h5
`define IR_MBOX_READ   4'h8
`define IR_MBOX_EN     4'h9
`define IR_BYPASS      4'hf

`define DR_LEN         16
`define DR_LEN_W       5
`define LEN_BYPASS     5'h01
`define LEN_MBOX       5'h08
`define LEN_PROG       5'h10

`define TGT_FLASH      4'h1
`define TGT_EEPROM     4'h2
`define TGT_FUSE       4'h3
`define TGT_LOCK       4'h4
`define TGT_ERASE      4'h5
`define DBG_FUSE_POS   7

`endif

/* dbg_pkg.sv */
/*
  Types shared by the debug mailbox and TAP gate and its TAP state machine.
  Assumes dbg_cfg.svh is on the include path.
*/
`include "dbg_cfg.svh"
package dbg_pkg;
  // TAP controller states, one-hot
  typedef enum logic [15:0] {
    TLR  = 16'h0001, RTI  = 16'h0002, SDRS = 16'h0004, CDR  = 16'h0008,
    SHDR = 16'h0010, E1DR = 16'h0020, PDR  = 16'h0040, E2DR = 16'h0080,
    UDR  = 16'h0100, SIRS = 16'h0200, CIR  = 16'h0400, SHIR = 16'h0800,
    E1IR = 16'h1000, PIR  = 16'h2000, E2IR = 16'h4000, UIR  = 16'h8000
  } tap_state_t;

  // CPU I/O access
  typedef struct packed {
    logic                 we;
    logic                 re;
    logic [`IO_AW-1:0]    addr;
    logic [7:0]           wdata;
  } io_req_t;

  // Programming command word from the debugger
  typedef struct packed {
    logic [3:0]  target;
    logic [11:0] data;
  } prog_cmd_t;
endpackage

/* tap_fsm.sv */
/*
  TAP controller state machine, stepped by a one-cycle enable on each
  rising edge of the sampled test clock.
  Assumes tms_i is already synchronised to clk_i.
*/
`timescale 1ns/1ps
module tap_fsm
  import dbg_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       step_i,
  input  wire logic       tms_i,
  input  wire logic       hold_i,
  output tap_state_t      state_o
);
  tap_state_t state_q;  // Current state
  tap_state_t state_d;  // Next state

  // Standard sixteen-state walk
  always_comb
  begin
    unique case (state_q)
      TLR:  state_d = tms_i ? TLR  : RTI;
      RTI:  state_d = tms_i ? SDRS : RTI;
      SDRS: state_d = tms_i ? SIRS : CDR;
      CDR:  state_d = tms_i ? E1DR : SHDR;
      SHDR: state_d = tms_i ? E1DR : SHDR;
      E1DR: state_d = tms_i ? UDR  : PDR;
      PDR:  state_d = tms_i ? E2DR : PDR;
      E2DR: state_d = tms_i ? UDR  : SHDR;
      UDR:  state_d = tms_i ? SDRS : RTI;
      SIRS: state_d = tms_i ? TLR  : CIR;
      CIR:  state_d = tms_i ? E1IR : SHIR;
      SHIR: state_d = tms_i ? E1IR : SHIR;
      E1IR: state_d = tms_i ? UIR  : PIR;
      PIR:  state_d = tms_i ? E2IR : PIR;
      E2IR: state_d = tms_i ? UIR  : SHIR;
      UIR:  state_d = tms_i ? SDRS : RTI;
      default: state_d = TLR;  // Illegal code recovers to reset
    endcase
  end

  // Hold in reset while the port is gated off
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      state_q <= TLR;
    else if (hold_i)
      state_q <= TLR;
    else if (step_i)
      state_q <= state_d;
  end

  assign state_o = state_q;
endmodule

/* dbg_mailbox_tap_gate.sv */
/*
  Debug mailbox and TAP gate: CPU-to-debugger mailbox byte with dirty flag,
  routing of a shared I/O address, TAP enable gating, a small TAP with
  mailbox, access-enable and programming data registers, and lock checks.
  Assumes TAP pins arrive asynchronously and TCK is far slower than ref_clk_i.
*/
`timescale 1ns/1ps
module dbg_mailbox_tap_gate
  import dbg_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire io_req_t     io_req_i,
  output logic [7:0]       io_rdata_o,
  input  wire logic        debug_enable_fuse_i,
  input  wire logic        tap_enable_fuse_i,
  input  wire logic        lock_bit_one_i,
  input  wire logic        lock_bit_two_i,
  input  wire logic        tck_i,
  input  wire logic        tms_i,
  input  wire logic        tdi_i,
  output logic             tdo_o,
  output logic             tdo_oe_o,
  output logic             tap_pins_port_o,
  output prog_cmd_t        prog_cmd_o,
  output logic             prog_req_o,
  input  wire logic [7:0]  prog_rdata_i
);
  logic [7:0]            mbox_q;       // Stored mailbox byte
  logic                  dirty_q;      // Mailbox dirty flag
  logic [7:0]            std_q;        // Ordinary register behind the address
  logic [7:0]            ctl_stat_q;   // Control/status with TAP disable bit
  logic                  access_en_q;  // Debugger has enabled mailbox access
  logic                  erased_q;     // Chip erase seen since reset
  logic [2:0]            tck_s_q;      // TCK sync pair plus edge history
  logic [1:0]            tms_s_q;      // TMS sync pair
  logic [1:0]            tdi_s_q;      // TDI sync pair
  logic [`IR_LEN-1:0]    ir_sr_q;      // Instruction shift stage
  logic [`IR_LEN-1:0]    ir_q;         // Active instruction
  logic [`DR_LEN-1:0]    dr_sr_q;      // Data shift stage
  logic [`DR_LEN-1:0]    dr_shift;     // Data shift stage after one bit
  logic [`DR_LEN_W-1:0]  dr_len;       // Length of selected data register
  tap_state_t            tap_state;    // TAP controller state
  logic                  tap_en;       // Port enabled
  logic                  tck_rise;     // Sampled rising TCK
  logic                  tck_fall;     // Sampled falling TCK
  logic                  mbox_sel;     // Shared address goes to mailbox
  logic                  mbox_wr;      // CPU mailbox write
  logic                  dbg_clear;    // Debugger fetched the mailbox
  logic                  upd_dr;       // Update-DR step
  logic                  fuse_block;   // Debug fuse programming refused
  prog_cmd_t             cmd;          // Command view of the shift stage

  // Port gate: fuse programmed and disable bit clear
  assign tap_en          = tap_enable_fuse_i & ~ctl_stat_q[`TAP_DIS_BIT];
  assign tap_pins_port_o = ~tap_en;

  // Pins come from outside; only the second stage (and TCK's third) is looked at
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tck_s_q <= 3'h0;
      tms_s_q <= 2'h0;
      tdi_s_q <= 2'h0;
    end
    else
    begin
      tck_s_q <= {tck_s_q[1:0], tck_i};
      tms_s_q <= {tms_s_q[0], tms_i};
      tdi_s_q <= {tdi_s_q[0], tdi_i};
    end
  end

  // Edges of the second and third stages only
  assign tck_rise = tap_en & tck_s_q[1] & ~tck_s_q[2];
  assign tck_fall = tap_en & ~tck_s_q[1] & tck_s_q[2];

  // TAP state machine, held in reset while gated off
  tap_fsm u_fsm (
    .clk_i   (ref_clk_i),
    .rstn_i  (rstn_i),
    .step_i  (tck_rise),
    .tms_i   (tms_s_q[1]),
    .hold_i  (~tap_en),
    .state_o (tap_state)
  );

  // Length of the data register the instruction selects
  always_comb
  begin
    unique case (ir_q)
      `IR_MBOX_READ: dr_len = `LEN_MBOX + `LEN_BYPASS;
      `IR_MBOX_EN:   dr_len = `LEN_BYPASS;
      `IR_PROG:      dr_len = `LEN_PROG;
      default:       dr_len = `LEN_BYPASS;  // Unknown codes act as bypass
    endcase
  end

  // One bit of shift: TDI enters at the top of the selected length
  generate
    for (genvar i = 0; i < `DR_LEN; i++)
    begin : g_shift
      if (i == `DR_LEN - 1)
      begin : g_top
        assign dr_shift[i] = (dr_len == `DR_LEN_W'(i + 1)) ? tdi_s_q[1] : 1'b0;
      end
      else
      begin : g_mid
        assign dr_shift[i] = (dr_len == `DR_LEN_W'(i + 1)) ? tdi_s_q[1] : dr_sr_q[i + 1];
      end
    end
  endgenerate

  // Instruction path; Test-Logic-Reset falls back to bypass
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ir_sr_q <= `IR_CAPTURE;
      ir_q    <= `IR_BYPASS;
    end
    else if (tap_state == TLR)
      ir_q <= `IR_BYPASS;
    else if (tck_rise)
    begin
      if (tap_state == CIR)
        ir_sr_q <= `IR_CAPTURE;
      else if (tap_state == SHIR)
        ir_sr_q <= {tdi_s_q[1], ir_sr_q[`IR_LEN-1:1]};
      else if (tap_state == UIR)
        ir_q <= ir_sr_q;
    end
  end

  // Data path capture and shift
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      dr_sr_q <= '0;
    else if (tck_rise && tap_state == CDR)
    begin
      unique case (ir_q)
        `IR_MBOX_READ: dr_sr_q <= {7'h00, dirty_q, mbox_q};
        `IR_MBOX_EN:   dr_sr_q <= {15'h0000, access_en_q};
        `IR_PROG:      dr_sr_q <= {erased_q, fuse_block, 6'h00, prog_rdata_i};
        default:       dr_sr_q <= '0;
      endcase
    end
    else if (tck_rise && tap_state == SHDR)
      dr_sr_q <= dr_shift;
  end

  // TDO changes on the falling edge, driven only while shifting
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end
    else if (!tap_en)
    begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_oe_o <= (tap_state == SHDR) || (tap_state == SHIR);
      tdo_o    <= (tap_state == SHIR) ? ir_sr_q[0] : dr_sr_q[0];
    end
  end

  // Update-DR actions
  assign upd_dr    = tck_rise && tap_state == UDR;
  assign dbg_clear = upd_dr && ir_q == `IR_MBOX_READ;
  assign cmd       = prog_cmd_t'(dr_sr_q);
  // Locked part may not program the debug fuse until erased
  assign fuse_block = (lock_bit_one_i | lock_bit_two_i) & ~erased_q
                      & (cmd.target == `TGT_FUSE) & ~cmd.data[`DBG_FUSE_POS];

  // Debugger enables mailbox access; TAP reset withdraws it
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      access_en_q <= 1'b0;
    else if (tap_state == TLR)
      access_en_q <= 1'b0;
    else if (upd_dr && ir_q == `IR_MBOX_EN)
      access_en_q <= dr_sr_q[0];
  end

  // Programming command out, one pulse per Update-DR; refused fuse writes dropped
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      prog_req_o <= 1'b0;
      prog_cmd_o <= '0;
      erased_q   <= 1'b0;
    end
    else
    begin
      prog_req_o <= upd_dr && ir_q == `IR_PROG && !fuse_block;
      if (upd_dr && ir_q == `IR_PROG && !fuse_block)
        prog_cmd_o <= cmd;
      if (upd_dr && ir_q == `IR_PROG && cmd.target == `TGT_ERASE)
        erased_q <= 1'b1;
    end
  end

  // Shared address routing
  assign mbox_sel = debug_enable_fuse_i & access_en_q;
  assign mbox_wr  = io_req_i.we && io_req_i.addr == `MBOX_ADDR && mbox_sel;

  // Mailbox byte and flag; a CPU write beats a same-cycle debugger clear
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      mbox_q  <= `MBOX_RESET;
      dirty_q <= 1'b0;
    end
    else if (mbox_wr)
    begin
      mbox_q  <= io_req_i.wdata;
      dirty_q <= 1'b1;
    end
    else if (dbg_clear)
      dirty_q <= 1'b0;
  end

  // Ordinary register and control/status register
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      std_q      <= `MBOX_RESET;
      ctl_stat_q <= `CTL_STAT_RESET;
    end
    else if (io_req_i.we)
    begin
      if (io_req_i.addr == `MBOX_ADDR && !mbox_sel)
        std_q <= io_req_i.wdata;
      if (io_req_i.addr == `CTL_STAT_ADDR)
        ctl_stat_q <= io_req_i.wdata;
    end
  end

  // Registered read data, zero for unknown addresses
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      io_rdata_o <= 8'h00;
    else if (io_req_i.re)
    begin
      if (io_req_i.addr == `MBOX_ADDR)
        io_rdata_o <= mbox_sel ? {dirty_q, mbox_q[6:0]} : std_q;
      else if (io_req_i.addr == `CTL_STAT_ADDR)
        io_rdata_o <= ctl_stat_q;
      else
        io_rdata_o <= 8'h00;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  a_mbox_write_dirty: assert property (mbox_wr |=> dirty_q && mbox_q == $past(io_req_i.wdata))
    else $error("mailbox write did not store byte and set dirty");
  a_mbox_read_msb: assert property (io_req_i.re && io_req_i.addr == `MBOX_ADDR && mbox_sel
    && !mbox_wr && !dbg_clear |=> io_rdata_o == {dirty_q, mbox_q[6:0]})
    else $error("mailbox read did not return dirty plus seven bits");
  a_dirty_cleared: assert property (dbg_clear && !mbox_wr |=> !dirty_q)
    else $error("debugger fetch did not clear dirty");
  a_route_std: assert property (io_req_i.we && io_req_i.addr == `MBOX_ADDR && !mbox_sel
    |=> $stable(mbox_q) && std_q == $past(io_req_i.wdata))
    else $error("shared address reached mailbox while not enabled");
  a_tap_gate: assert property (ctl_stat_q[`TAP_DIS_BIT] |-> ##1 tap_state == TLR ##1 !tdo_oe_o)
    else $error("TAP active with disable bit set");
  a_fuse_refused: assert property (upd_dr && ir_q == `IR_PROG && fuse_block |=> !prog_req_o)
    else $error("debug fuse programmed on locked part");
  a_port_pins: assert property (!tap_enable_fuse_i |-> tap_pins_port_o ##1 tap_state == TLR)
    else $error("TAP not held in reset with fuse off");
  // Enable is only set on a fall, so at most one rise (shift to exit-1) can lie under it
  a_tdo_float: assert property (tdo_oe_o |-> tap_state inside {SHDR, E1DR, SHIR, E1IR})
    else $error("TDO driven outside shift");
  a_overwrite_keep: assert property (dirty_q && mbox_wr |=> dirty_q)
    else $error("overwrite dropped dirty flag");
  a_prog_pulse: assert property (prog_req_o |=> !prog_req_o)
    else $error("programming request longer than one cycle");

  c_mbox_fetch: cover property (mbox_wr ##[1:1000] dbg_clear);
  c_prog_cmd:   cover property (prog_req_o);
  c_refused:    cover property (upd_dr && fuse_block);
  c_shift_dr:   cover property (tdo_oe_o && tap_state == SHDR);
endmodule

/* jtag_host_model.sv */
/*
  Behavioural debugger on the far side of the test access port.
  Assumes the test data line is pulled up by the bench when undriven.
*/
`timescale 1ns/1ps
module jtag_host_model
(
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i
);
  localparam int HALF = 40; // Half of the 80 ns test clock

  // Only these four pins are driven or observed
  initial
  begin
    tck_o = 1'b0; // Clock stands still low between frames
    tms_o = 1'b1;
    tdi_o = 1'b0; // Zero fill, so reserved scan cells never see a one
  end

  // One test clock; data line read just before the rise
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
  begin
    tms_o = tms;
    tdi_o = tdi;
    #HALF;
    tdo = tdo_i;
    tck_o = 1'b1;
    #HALF;
    tck_o = 1'b0;
  end
  endtask

  // Five ones reach reset from any state, then park in idle
  task automatic tap_reset;
    logic d;
  begin
    repeat (5) tick(1'b1, 1'b0, d);
    tick(1'b0, 1'b0, d);
  end
  endtask

  // Scan n bits LSB first through the instruction or data path
  task automatic shift(input logic ir, input int n, input logic [15:0] din,
                       output logic [15:0] dout);
    logic d;
    int   i;
  begin
    dout = 16'h0000;
    tick(1'b1, 1'b0, d);
    if (ir)
      tick(1'b1, 1'b0, d);
    tick(1'b0, 1'b0, d); // Capture
    tick(1'b0, 1'b0, d); // Into shift
    for (i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], d);
      dout[i] = d;
    end
    tick(1'b1, 1'b0, d); // Update
    tick(1'b0, 1'b0, d); // Back to idle
  end
  endtask
endmodule

/* tb_dbg_mailbox_tap_gate.sv */
/*
  Self-checking bench for the debug mailbox and TAP gate.
  Assumes jtag_host_model drives the test pins; TDO line has a pull-up.
*/
`timescale 1ns/1ps
module tb_dbg_mailbox_tap_gate
  import dbg_pkg::*;
;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  io_req_t    io_req = '0;
  logic [7:0] io_rdata;
  logic       dbg_fuse = 1'b0;
  logic       tap_fuse = 1'b1;
  logic       lock_one = 1'b0;
  logic       lock_two = 1'b0;
  logic       tck;
  logic       tms;
  logic       tdi;
  logic       tdo;
  logic       tdo_oe;
  logic       pins_port;
  prog_cmd_t  prog_cmd;
  logic       prog_req;
  prog_cmd_t  last_cmd = '0;
  int         n_req = 0;
  int         n_fail = 0;
  int         checked = 0;
  logic [15:0] r;
  logic [7:0]  b;
  wire        tdo_line = tdo_oe ? tdo : 1'b1; // Pull-up when floating

  always #2.5 clk = ~clk;

  dbg_mailbox_tap_gate u_dbg_mailbox_tap_gate (
    .ref_clk_i(clk), .rstn_i(rstn), .io_req_i(io_req), .io_rdata_o(io_rdata),
    .debug_enable_fuse_i(dbg_fuse), .tap_enable_fuse_i(tap_fuse),
    .lock_bit_one_i(lock_one), .lock_bit_two_i(lock_two), .tck_i(tck),
    .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .tap_pins_port_o(pins_port), .prog_cmd_o(prog_cmd), .prog_req_o(prog_req),
    .prog_rdata_i(8'h5a));

  jtag_host_model u_jtag_host_model (
    .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_line));

  // Count programming strobes and keep the last command
  always @(posedge clk)
    if (prog_req === 1'b1)
    begin
      n_req <= n_req + 1;
      last_cmd <= prog_cmd;
    end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
  begin
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  end
  endtask

  // One idle edge first, so a strobe is never raised in the step it fell
  task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
  begin
    @(posedge clk);
    #1;
    io_req = '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    #1;
    io_req = '0;
  end
  endtask

  task automatic io_rd(input logic [5:0] a, output logic [7:0] d);
  begin
    @(posedge clk);
    #1;
    io_req = '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    #1;
    io_req = '0;
    @(posedge clk);
    #1;
    d = io_rdata;
  end
  endtask

  // Fetch the mailbox over the TAP; its update clears the dirty flag
  task automatic tap_fetch(output logic [15:0] v);
  begin
    u_jtag_host_model.shift(1'b1, 4, 16'h0008, v);
    u_jtag_host_model.shift(1'b0, 9, 16'h0000, v);
  end
  endtask

  // One programming word; expect a strobe only when ok
  task automatic prog(input logic [15:0] w, input logic ok);
    int n0;
  begin
    n0 = n_req;
    u_jtag_host_model.shift(1'b0, 16, w, r);
    chk({8'h00, r[7:0]}, 16'h005a, "prog read-back");
    chk(16'(n_req - n0), {15'h0000, ok}, "prog strobe count");
    if (ok)
      chk(last_cmd, w, "prog command");
  end
  endtask

  task automatic t_gate;
  begin
    io_rd(6'h34, b);
    chk({8'h00, b}, 16'h0000, "ctrl reset");
    chk({15'h0000, pins_port}, 16'h0000, "fuse on, bit clear");
    tap_fuse = 1'b0;
    #1;
    chk({15'h0000, pins_port}, 16'h0001, "fuse off port pins");
    u_jtag_host_model.shift(1'b1, 4, 16'h000f, r);
    chk(r, 16'h000f, "held TAP never drives");
    tap_fuse = 1'b1;
    io_wr(6'h34, 8'h80);
    #1;
    chk({15'h0000, pins_port}, 16'h0001, "disable bit");
    io_wr(6'h34, 8'h00);
    u_jtag_host_model.tap_reset();
    u_jtag_host_model.shift(1'b1, 4, 16'h000f, r);
    chk(r, 16'h0001, "IR capture when enabled");
    chk({15'h0000, tdo_oe}, 16'h0000, "TDO floats in idle");
    $display("done gate");
  end
  endtask

  task automatic t_route;
  begin
    dbg_fuse = 1'b1;
    io_wr(6'h31, 8'h3c);
    tap_fetch(r);
    chk(r, 16'h0000, "no debugger enable");
    dbg_fuse = 1'b0;
    u_jtag_host_model.shift(1'b1, 4, 16'h0009, r);
    u_jtag_host_model.shift(1'b0, 1, 16'h0001, r);
    io_wr(6'h31, 8'h3c);
    io_rd(6'h31, b);
    chk({8'h00, b}, 16'h003c, "ordinary register read");
    tap_fetch(r);
    chk(r, 16'h0000, "fuse not programmed");
    dbg_fuse = 1'b1;
    $display("done route");
  end
  endtask

  task automatic t_mbox;
  begin
    io_wr(6'h31, 8'h25);
    io_rd(6'h31, b);
    chk({8'h00, b}, 16'h00a5, "dirty in bit 7");
    io_wr(6'h31, 8'h13);
    io_rd(6'h31, b);
    chk({8'h00, b}, 16'h0093, "overwrite while dirty");
    tap_fetch(r);
    chk(r, 16'h0113, "debugger fetch");
    io_rd(6'h31, b);
    chk({8'h00, b}, 16'h0013, "dirty cleared");
    $display("done mbox");
  end
  endtask

  task automatic t_prog;
    int t;
  begin
    u_jtag_host_model.shift(1'b1, 4, 16'h0005, r);
    for (t = 1; t <= 4; t++)
      prog({4'(t), 12'h0c0 | 12'(t)}, 1'b1);
    lock_one = 1'b1;
    prog(16'h3000, 1'b0);
    prog(16'h5000, 1'b1);
    prog(16'h3000, 1'b1);
    // Mid-run reset forgets the erase; the other lock bit must refuse too
    lock_one = 1'b0;
    lock_two = 1'b1;
    @(posedge clk);
    #1;
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    u_jtag_host_model.tap_reset();
    u_jtag_host_model.shift(1'b1, 4, 16'h0005, r);
    prog(16'h3000, 1'b0);
    $display("done prog");
  end
  endtask

  task automatic finish_test;
  begin
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask

  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    #1;
    rstn = 1'b1;
    repeat (4) @(posedge clk);
    t_gate();
    t_route();
    t_mbox();
    t_prog();
    finish_test();
  end

  // Watchdog, well beyond the roughly 25 us the tests need
  initial
  begin
    #300000;
    n_fail++;
    finish_test();
  end
endmodule
